// >>> logic/i2cm_bit_engine.sv
/*
  Bit level engine: START, STOP, one written bit or one read bit, in four quarters.
  Assumes open-drain pins resolved outside and pin inputs synchronous to clk_i.
*/
module i2cm_bit_engine
  import i2cm_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic req_i,
  input wire i2cm_op_t op_i,
  input wire logic bit_i,
  input wire logic sda_i,
  output logic done_o,
  output logic rbit_o,
  output logic lost_o,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o
);

  localparam int CW = $clog2(QTR + 1);

  if (QTR < 1)
  begin : g_bad_qtr
    $error("QTR must be at least one cycle.");
  end

  typedef struct packed {
    logic active;
    i2cm_op_t op;
    logic wbit;
    logic [1:0] quarter;
    logic [CW-1:0] count;
    logic scl;
    logic sda;
    logic rbit;
    logic lost;
    logic done;
  } i2cm_eng_t;

  i2cm_eng_t s;
  i2cm_eng_t next_s;

  // Returns {scl, sda} for one quarter of an operation.
  function automatic logic [1:0] levels(i2cm_op_t op, logic [1:0] q, logic d);
    logic [1:0] r;
    r = 2'h3;
    case (op)
      OP_START: r = (q < 2'h2) ? 2'h3 : ((q == 2'h2) ? 2'h2 : 2'h0);
      OP_STOP: r = (q == 2'h0) ? 2'h0 : ((q == 2'h1) ? 2'h2 : 2'h3);
      OP_WRITE: r = {(q == 2'h1) || (q == 2'h2), d};
      OP_READ: r = {(q == 2'h1) || (q == 2'h2), 1'b1};
      default: r = 2'h3;
    endcase
    return r;
  endfunction : levels

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    if (s.active)
    begin
      if (s.count == CW'(QTR - 1))
      begin
        next_s.count = '0;
        next_s.quarter = s.quarter + 2'h1;
        if (s.quarter == 2'h3)
        begin
          next_s.active = 1'b0;
          next_s.done = 1'b1;
        end
        else
        begin
          {next_s.scl, next_s.sda} = levels(s.op, s.quarter + 2'h1, s.wbit);
          if (s.lost)
          begin
            // Having lost the bus, let go of both wires at once.
            {next_s.scl, next_s.sda} = 2'h3;
          end
        end
        if (s.quarter == 2'h2)
        begin
          next_s.rbit = sda_i;
          next_s.lost = (s.op == OP_WRITE) && s.sda && !sda_i;
          if ((s.op == OP_WRITE) && s.sda && !sda_i)
          begin
            {next_s.scl, next_s.sda} = 2'h3;
          end
        end
      end
      else
      begin
        next_s.count = s.count + CW'(1);
      end
    end
    else if (req_i)
    begin
      next_s.active = 1'b1;
      next_s.op = op_i;
      next_s.wbit = bit_i;
      next_s.quarter = 2'h0;
      next_s.count = '0;
      next_s.lost = 1'b0;
      {next_s.scl, next_s.sda} = levels(op_i, 2'h0, bit_i);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '{active: 1'b0, op: OP_START, wbit: 1'b1, quarter: 2'h0, count: '0,
             scl: 1'b1, sda: 1'b1, rbit: 1'b1, lost: 1'b0, done: 1'b0};
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  assign done_o = s.done;
  assign rbit_o = s.rbit;
  assign lost_o = s.lost;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = !s.scl;
  assign sda_oe_o = !s.sda;

endmodule : i2cm_bit_engine

// >>> logic/i2cm_master.sv
/*
  Two-wire bus master: Wishbone register file, command decoding from Idle,
  byte sequencing and status reporting.
  Assumes classic Wishbone single cycles, open-drain pins resolved outside,
  and pin inputs synchronous to clk_i.
*/
// Register access over Wishbone was chosen for this implementation.
module i2cm_master
  import i2cm_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic done_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    i2cm_step_t step;
    i2cm_mode_t mode;
    logic [7:0] target;
    logic [7:0] data;
    logic [7:0] shift;
    logic [2:0] cnt;
    logic do_stop;
    logic rx;
    logic ack_en;
    logic busy;
    logic arb;
    logic dnack;
    logic anack;
    logic bus_occ;
    logic scl_q;
    logic sda_q;
    logic ack;
    logic [31:0] rdat;
    logic done;
  } i2cm_state_t;

  i2cm_state_t s;
  i2cm_state_t next_s;

  logic eng_req;
  i2cm_op_t eng_op;
  logic eng_bit;
  logic eng_done;
  logic eng_rbit;
  logic eng_lost;
  logic wr_req;
  logic rd_req;
  logic [3:0] cmd;
  logic legal;

  // Builds the seven status bits as software reads them.
  function automatic logic [31:0] status_word(i2cm_state_t st);
    logic [31:0] w;
    w = '0;
    w[ST_BUS_OCC] = st.bus_occ;
    w[ST_IDLE] = (st.mode == MODE_IDLE) && !st.busy;
    w[ST_ARB] = st.arb;
    w[ST_DNACK] = st.dnack;
    w[ST_ANACK] = st.anack;
    w[ST_ERR] = st.arb || st.dnack || st.anack;
    w[ST_BUSY] = st.busy;
    return w;
  endfunction : status_word

  // ****************************************************************
  // Bit engine
  // ****************************************************************
  i2cm_bit_engine #(
    .QTR(QTR)
  ) u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .req_i(eng_req),
    .op_i(eng_op),
    .bit_i(eng_bit),
    .sda_i(sda_i),
    .done_o(eng_done),
    .rbit_o(eng_rbit),
    .lost_o(eng_lost),
    .scl_o(scl_o),
    .scl_oe_o(scl_oe_o),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o)
  );

  // The engine's done cycle is the turnaround: without this gate it would restart the old step.
  assign eng_req = (s.step != SQ_IDLE) && !eng_done;

  always_comb
  begin
    eng_op = OP_START;
    eng_bit = 1'b1;
    case (s.step)
      SQ_START: eng_op = OP_START;
      SQ_ADDR:
      begin
        eng_op = OP_WRITE;
        eng_bit = s.shift[LAST_BIT];
      end
      SQ_AACK: eng_op = OP_READ;
      SQ_DATA:
      begin
        eng_op = s.rx ? OP_READ : OP_WRITE;
        eng_bit = s.rx ? 1'b1 : s.shift[LAST_BIT];
      end
      SQ_DACK:
      begin
        eng_op = s.rx ? OP_WRITE : OP_READ;
        eng_bit = !s.ack_en;
      end
      SQ_STOP: eng_op = OP_STOP;
      default: eng_op = OP_START;
    endcase
  end

  // ****************************************************************
  // Bus access and command decoding
  // ****************************************************************
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !s.ack && wb_sel_i[0];
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !s.ack;
  assign cmd = wb_dat_i[3:0];

  // Idle decode: start and run set, one combination refused.
  always_comb
  begin
    legal = cmd[CMD_START] && cmd[CMD_RUN];
    if (s.target[DIR_BIT] && cmd[CMD_ACK] && cmd[CMD_STOP])
    begin
      legal = 1'b0;
    end
    if ((s.mode != MODE_IDLE) || s.busy)
    begin
      legal = 1'b0;
    end
  end

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    next_s.scl_q = scl_i;
    next_s.sda_q = sda_i;
    if (s.scl_q && scl_i && s.sda_q && !sda_i)
    begin
      next_s.bus_occ = 1'b1;
    end
    else if (s.scl_q && scl_i && !s.sda_q && sda_i)
    begin
      next_s.bus_occ = 1'b0;
    end
    if (rd_req)
    begin
      case (wb_adr_i)
        ADDR_TARGET: next_s.rdat = {24'h00_0000, s.target};
        ADDR_CMDSTAT: next_s.rdat = status_word(s);
        ADDR_DATA: next_s.rdat = {24'h00_0000, s.data};
        default: next_s.rdat = '0;
      endcase
    end
    if (wr_req)
    begin
      case (wb_adr_i)
        ADDR_TARGET: next_s.target = wb_dat_i[7:0];
        ADDR_DATA: next_s.data = wb_dat_i[7:0];
        ADDR_CMDSTAT:
        begin
          if (legal)
          begin
            next_s.busy = 1'b1;
            next_s.step = SQ_START;
            next_s.rx = s.target[DIR_BIT];
            next_s.do_stop = cmd[CMD_STOP];
            next_s.ack_en = cmd[CMD_ACK];
            next_s.arb = 1'b0;
            next_s.dnack = 1'b0;
            next_s.anack = 1'b0;
          end
          else if ((s.mode != MODE_IDLE) && !s.busy && (cmd == 4'h4))
          begin
            // A lone stop lets software give the bus back after a held transfer.
            next_s.busy = 1'b1;
            next_s.step = SQ_STOP;
            next_s.do_stop = 1'b1;
          end
        end
        default: next_s.target = s.target;
      endcase
    end

    // ****************************************************************
    // Byte sequencing
    // ****************************************************************
    if (eng_done)
    begin
      case (s.step)
        SQ_START:
        begin
          next_s.step = SQ_ADDR;
          next_s.shift = s.target;
          next_s.cnt = 3'h7;
        end
        SQ_ADDR:
        begin
          if (eng_lost)
          begin
            next_s.arb = 1'b1;
            next_s.step = SQ_IDLE;
            next_s.mode = MODE_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end
          else if (s.cnt == 3'h0)
          begin
            next_s.step = SQ_AACK;
          end
          else
          begin
            next_s.shift = {s.shift[6:0], 1'b0};
            next_s.cnt = s.cnt - 3'h1;
          end
        end
        SQ_AACK:
        begin
          if (eng_rbit)
          begin
            next_s.anack = 1'b1;
            next_s.step = SQ_STOP;
            next_s.do_stop = 1'b1;
          end
          else
          begin
            next_s.step = SQ_DATA;
            next_s.shift = s.rx ? REG_RESET : s.data;
            next_s.cnt = 3'h7;
          end
        end
        SQ_DATA:
        begin
          if (!s.rx && eng_lost)
          begin
            next_s.arb = 1'b1;
            next_s.step = SQ_IDLE;
            next_s.mode = MODE_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end
          else
          begin
            next_s.shift = {s.shift[6:0], s.rx ? eng_rbit : 1'b0};
            next_s.cnt = s.cnt - 3'h1;
            if (s.cnt == 3'h0)
            begin
              next_s.step = SQ_DACK;
            end
          end
        end
        SQ_DACK:
        begin
          if (s.rx)
          begin
            next_s.data = s.shift;
          end
          if (!s.rx && eng_rbit)
          begin
            next_s.dnack = 1'b1;
            next_s.step = SQ_STOP;
            next_s.do_stop = 1'b1;
          end
          else if (s.do_stop)
          begin
            next_s.step = SQ_STOP;
          end
          else
          begin
            next_s.step = SQ_IDLE;
            next_s.mode = s.rx ? MODE_RX : MODE_TX;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end
        end
        SQ_STOP:
        begin
          next_s.step = SQ_IDLE;
          next_s.mode = MODE_IDLE;
          next_s.busy = 1'b0;
          next_s.done = 1'b1;
        end
        default: next_s.step = SQ_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Clock enable low freezes everything, including the bus answer.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '{step: SQ_IDLE, mode: MODE_IDLE, target: REG_RESET, data: REG_RESET,
             shift: REG_RESET, cnt: 3'h0, do_stop: 1'b0, rx: 1'b0, ack_en: 1'b0,
             busy: 1'b0, arb: 1'b0, dnack: 1'b0, anack: 1'b0, bus_occ: 1'b0,
             scl_q: 1'b1, sda_q: 1'b1, ack: 1'b0, rdat: 32'h0000_0000, done: 1'b0};
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;
  assign done_o = s.done;

endmodule : i2cm_master

// >>> logic/i2cm_pkg.sv
/*
  Shared constants and types of the two-wire bus master command and status block.
  Assumes a 25 MHz system clock and a classic Wishbone slave with byte addresses.
*/
// Operation
// - status bit 6 shows bus occupied by START/STOP
// - status bit 5 reads one while controller idle
// - status bit 4 set on lost arbitration
// - status bit 3 set on unacknowledged data byte
// - status bit 2 set on unacknowledged address
// - status bit 1 flags any of those errors
// - status bit 0 busy; other bits then invalid
// - command bit 3 acknowledges each received byte
// - command bit 2 requests a STOP condition
// - command bit 1 requests START or repeated START; the code accepts it only from Idle and never sends a repeated START
// - command bit 0 permits the byte transfer
// - idle send start run: START, send, transmit
// - idle send stop start run: START, send, STOP
// - idle receive no-ack start run: one nacked byte
// - idle receive no-ack stop start run: receive, STOP
// - idle receive ack start run: acked byte, receive
// - target address bit 0 selects send or receive
// - completion or abort pulses the done output
package i2cm_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] ADDR_TARGET = 8'h00;
  localparam logic [7:0] ADDR_CMDSTAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int ST_BUS_OCC = 6;
  localparam int ST_IDLE = 5;
  localparam int ST_ARB = 4;
  localparam int ST_DNACK = 3;
  localparam int ST_ANACK = 2;
  localparam int ST_ERR = 1;
  localparam int ST_BUSY = 0;
  localparam int CMD_ACK = 3;
  localparam int CMD_STOP = 2;
  localparam int CMD_START = 1;
  localparam int CMD_RUN = 0;
  localparam int DIR_BIT = 0;
  localparam int LAST_BIT = 7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ = 2'h3
  } i2cm_op_t;

  typedef enum logic [6:0] {
    SQ_IDLE = 7'h01,
    SQ_START = 7'h02,
    SQ_ADDR = 7'h04,
    SQ_AACK = 7'h08,
    SQ_DATA = 7'h10,
    SQ_DACK = 7'h20,
    SQ_STOP = 7'h40
  } i2cm_step_t;

  typedef enum logic [2:0] {
    MODE_IDLE = 3'h1,
    MODE_TX = 3'h2,
    MODE_RX = 3'h4
  } i2cm_mode_t;

endpackage : i2cm_pkg

// >>> verification/i2cm_master_props.sv
/*
  Port checker of the two-wire bus master.
  Assumes it is bound to i2cm_master and that ce_i stays high.
*/
module i2cm_master_props
  import i2cm_pkg::*;
#(
  parameter int QTR = 2
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o,
  input wire logic done_o
);
  // ********
  // Properties
  // ********
  localparam int CLK_GAP = 2 * QTR + 2;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic rd_st;
  assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i == ADDR_CMDSTAT;
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !(wb_adr_i inside {8'h00, 8'h04, 8'h08})
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_idle_busy: assert property (rd_st |-> !(wb_dat_o[ST_IDLE] && wb_dat_o[ST_BUSY]))
    else $error("idle and busy together");
  a_error_sum: assert property (rd_st && !wb_dat_o[ST_BUSY]
    |-> wb_dat_o[ST_ERR] == |wb_dat_o[ST_ARB:ST_ANACK])
    else $error("error bit not sum of causes");
  a_one_cause: assert property (rd_st && !wb_dat_o[ST_BUSY]
    |-> $onehot0(wb_dat_o[ST_ARB:ST_ANACK]))
    else $error("several error causes at once");
  a_idle_wires: assert property (rd_st && wb_dat_o[ST_IDLE] && !wb_dat_o[ST_BUS_OCC]
    |-> !scl_oe_o && !sda_oe_o)
    else $error("wires held while idle and bus free");
  a_start_clock: assert property ($rose(sda_oe_o) && !scl_oe_o |-> ##[1:CLK_GAP] scl_oe_o)
    else $error("no clock after start");
endmodule : i2cm_master_props

bind i2cm_master i2cm_master_props #(.QTR(QTR)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .done_o(done_o));

// >>> verification/i2cm_master_tb.sv
/*
  Self-checking bench of the two-wire bus master against a behavioural model.
  Assumes the package, the design and the slave model are compiled first.
*/
module i2cm_master_tb;
  import i2cm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, cyc, stb, we, ack, scl_oe, sda_oe, s_oe, done, mack, aa, ad, clash;
  logic scl_w, sda_w, scl_lo, sda_lo;
  logic [7:0] adr, got, rb;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int failures, checks, dones, last_fl;
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || s_oe);
  i2cm_master #(.QTR(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .scl_i(scl_w), .scl_o(scl_lo), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_lo),
    .sda_oe_o(sda_oe), .done_o(done));
  i2cm_slave_model u_slave (.scl_i(scl_w), .sda_i(sda_w), .ack_addr_i(aa), .ack_data_i(ad),
    .clash_i(clash), .rd_byte_i(rb), .sda_oe_o(s_oe), .got_o(got), .mack_o(mack));
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = !clk_i;
  end
  always @(posedge clk_i)
    if (done === 1'b1)
      dones <= dones + 1;
  // ********
  // Tasks
  // ********
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 50)
    begin
      failures++;
      print_verdict();
    end
  endtask : xfer
  task automatic poll;
    int n;
    q = 32'h0000_0001;
    for (n = 0; n < 300 && q[ST_BUSY] !== 1'b0; n++)
      xfer(1'b0, ADDR_CMDSTAT, 32'h0000_0000, 4'hf);
    if (q[ST_BUSY] !== 1'b0)
    begin
      failures++;
      print_verdict();
    end
  endtask : poll
  task automatic run(input int dir, input int cmd);
    int ok, st;
    logic [7:0] ta, d;
    ta = 8'($urandom);
    ta[DIR_BIT] = dir[0];
    ta[LAST_BIT] = ta[LAST_BIT] | clash;
    d = 8'($urandom);
    aa <= ($urandom % 4) != 0;
    ad <= ($urandom % 4) != 0;
    rb <= 8'($urandom);
    xfer(1'b1, ADDR_TARGET, 32'(ta), 4'hf);
    xfer(1'b1, ADDR_DATA, 32'(d), 4'hf);
    dones = 0;
    xfer(1'b1, ADDR_CMDSTAT, 32'(cmd), 4'hf);
    xfer(1'b0, ADDR_CMDSTAT, 32'h0000_0000, 4'hf);
    ok = cmd[1] & cmd[0] & !(dir[0] & cmd[3] & cmd[2]);
    check("busy", 32'(q[ST_BUSY]), 32'(ok));
    poll();
    st = ok ? 8'h20 : 8'h20 | last_fl;
    if (ok && clash)
      st = 8'h32;
    else if (ok && !aa)
      st = 8'h26;
    else if (ok && dir == 0 && !ad)
      st = 8'h2a;
    else if (ok && !cmd[2])
      st = 8'h40;
    last_fl = st & 8'h1e;
    check("status", q, 32'(st));
    check("done", 32'(dones), 32'(ok));
    xfer(1'b0, ADDR_DATA, 32'h0000_0000, 4'hf);
    check("data", q, 32'((ok && aa && dir == 1 && !clash) ? rb : d));
    if (ok && aa && !clash && dir == 0)
      check("sent", 32'(got), 32'(d));
    if (ok && aa && !clash && dir == 1)
      check("mack", 32'(mack), 32'(!cmd[3]));
    if (st == 8'h40)
    begin
      xfer(1'b1, ADDR_CMDSTAT, 32'h0000_0004, 4'hf);
      poll();
      check("stop", q, 32'h0000_0020);
    end
    $display("test dir %0d cmd %0d done", dir, cmd);
  endtask : run
  // ********
  // Sequence
  // ********
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, aa, ad, clash} = 6'h00;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    rb = 8'h00;
    failures = 0;
    checks = 0;
    dones = 0;
    last_fl = 0;
    void'($urandom(32'h62ef_c81a));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    xfer(1'b0, ADDR_CMDSTAT, 32'h0000_0000, 4'hf);
    check("status reset", q, 32'h0000_0020);
    check("drive levels", 32'({scl_lo, sda_lo}), 32'h0000_0000);
    xfer(1'b1, ADDR_TARGET, 32'h0000_005a, 4'h0);
    xfer(1'b1, 8'h0c, 32'h0000_00ff, 4'hf);
    xfer(1'b0, ADDR_TARGET, 32'h0000_0000, 4'hf);
    check("target", q, 32'h0000_0000);
    xfer(1'b0, 8'h0c, 32'h0000_0000, 4'hf);
    check("unmapped", q, 32'h0000_0000);
    $display("test registers done");
    for (int dr = 0; dr < 2; dr++)
      for (int c = 0; c < 16; c++)
        if (!(dr == 1 && c == 15))
          run(dr, c);
    clash = 1'b1;
    run(0, 7);
    print_verdict();
  end
endmodule : i2cm_master_tb

// >>> verification/i2cm_slave_model.sv
/*
  Slave on the two-wire bus: one address byte and one data byte a frame.
  Assumes resolved wires with pull-ups on scl_i and sda_i.
*/
module i2cm_slave_model
(
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_addr_i,
  input wire logic ack_data_i,
  input wire logic clash_i,
  input wire logic [7:0] rd_byte_i,
  output logic sda_oe_o,
  output logic [7:0] got_o,
  output logic mack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int i;
  initial
  begin
    sda_oe_o = 1'b0;
    forever
    begin
      @(negedge sda_i iff scl_i === 1'b1);
      if (clash_i)
      begin
        // Pulling low against a driven one; the release, after the master lets go but before
        // it reports idle, reads as a STOP. It falls on a falling clock edge, between rising edges, to avoid a race.
        @(negedge scl_i) sda_oe_o = 1'b1;
        @(posedge scl_i) #220 sda_oe_o = 1'b0;
      end
      else
      begin
        repeat (8) @(posedge scl_i) got_o = {got_o[6:0], sda_i};
        @(negedge scl_i) sda_oe_o = ack_addr_i;
        @(negedge scl_i) sda_oe_o = 1'b0;
        if (ack_addr_i && got_o[0])
        begin
          for (i = 7; i >= 0; i--)
          begin
            sda_oe_o = !rd_byte_i[i];
            @(negedge scl_i);
          end
          sda_oe_o = 1'b0;
          @(posedge scl_i) mack_o = sda_i;
        end
        else if (ack_addr_i)
        begin
          repeat (8) @(posedge scl_i) got_o = {got_o[6:0], sda_i};
          @(negedge scl_i) sda_oe_o = ack_data_i;
          @(negedge scl_i) sda_oe_o = 1'b0;
        end
      end
    end
  end
endmodule : i2cm_slave_model
